/* File: verilog/ptmr_pkg.sv */
// constants and types shared by the periodic tick unit
package ptmr_pkg;
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] MODULUS_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] MASK_OFFSET = 12'h00C;
    localparam logic [11:0] SOURCE_OFFSET = 12'h010;
    // periodic_irq_control layout
    localparam int LEVEL_LSB = 8;
    localparam int LEVEL_MSB = 10;
    localparam int VECTOR_LSB = 0;
    localparam int VECTOR_MSB = 7;
    localparam logic [15:0] CTRL_RESET = 16'h000F;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'h07FF;
    // periodic_timer_modulus layout
    localparam int PRESCALE_BIT = 8;
    localparam int MODULUS_LSB = 0;
    localparam int MODULUS_MSB = 7;
    localparam logic [7:0] MODULUS_RESET = 8'h00;
    // status and mask layout
    localparam int EXPIRE_BIT = 0;
    localparam int REQ_ACK_BIT = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // timing: four crystal periods per base tick, optional divide by 512
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int CRYSTAL_DIV = 4;
    localparam int PRESCALE_DIV = 512;
    localparam logic [1:0] CRYSTAL_LAST = 2'(CRYSTAL_DIV - 1);
    localparam logic [8:0] PRESCALE_LAST = 9'(PRESCALE_DIV - 1);
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    typedef logic [2:0] ptmr_level_t;
    typedef logic [7:0] ptmr_vector_t;
endpackage

/* File: verilog/ptmr_tick_if.sv */
`timescale 1ns/1ps
// tick link between the register block and the prescaler
interface ptmr_tick_if;
    logic prescaleSel;
    logic running;
    logic tick;
    modport ctrl (output prescaleSel, output running, input tick);
    modport gen (input prescaleSel, input running, output tick);
endinterface

/* File: verilog/ptmr_prescaler.sv */
`timescale 1ns/1ps
// base divide-by-four and optional divide-by-512 tick generator
module ptmr_prescaler
    import ptmr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // tick link
    ptmr_tick_if.gen link
);
    logic [1:0] baseCnt_ff;
    logic [8:0] preCnt_ff;
    logic baseTick;
    logic tick_ff;

    assign baseTick = (baseCnt_ff == CRYSTAL_LAST);

    // four crystal periods per counted tick
    always_ff @(posedge clock) begin
        if (!rst_b || !link.running) begin
            baseCnt_ff <= 2'h0;
        end else begin
            baseCnt_ff <= baseTick ? 2'h0 : baseCnt_ff + 2'h1;
        end
    end

    // divide-by-512 stage, bypassed when prescale is off
    always_ff @(posedge clock) begin
        if (!rst_b || !link.running) begin
            preCnt_ff <= 9'h000;
        end else if (baseTick) begin
            preCnt_ff <= (preCnt_ff == PRESCALE_LAST) ? 9'h000 : preCnt_ff + 9'h001;
        end
    end

    // one-cycle tick pulse
    always_ff @(posedge clock) begin
        if (!rst_b || !link.running) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= baseTick && (!link.prescaleSel || preCnt_ff == PRESCALE_LAST); // RULE7 RULE9
        end
    end

    assign link.tick = tick_ff;
endmodule

/* File: verilog/ptmr_periodic_timer.sv */
`timescale 1ns/1ps
// periodic tick unit: apb registers, modulus counter, request and acknowledge
//
// Operation
// RULE1: level zero disables; else request at level
// RULE2: equal level ties go to timer first
// RULE3: counter keeps running while level disabled
// RULE4: acknowledge returns programmed eight-bit vector
// RULE5: zero modulus stops timer completely
// RULE6: modulus register accessible at any time
// RULE7: prescale bit selects divide by 512
// RULE8: prescale bit resets to inverted strap
// RULE9: period is modulus times prescale times four
// RULE10: control top five bits read zero
// RULE11: strap at reset selects clock source
// RULE12: count down, reload, hold request until acknowledged
module ptmr_periodic_timer
    import ptmr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap pin
    input wire logic clockSourceStrap,
    output logic clockSourceSynth,
    // interrupt arbitration and acknowledge
    input wire ptmr_pkg::ptmr_level_t extIrqLevel,
    input wire logic iackReq,
    input wire ptmr_pkg::ptmr_level_t iackLevel,
    output ptmr_pkg::ptmr_level_t irqLevelOut,
    output logic ackValid,
    output logic ackExternal,
    output ptmr_pkg::ptmr_vector_t ackVector,
    // sticky-status interrupt
    output logic irq
);
    import ptmr_pkg::*;

    ////////////////////////////////////////////////////////////////
    // declarations
    ptmr_tick_if tickLink ();
    logic [10:0] ctrl_ff;
    logic prescale_ff;
    logic [7:0] modulus_ff;
    logic [7:0] count_ff;
    logic pending_ff;
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic [31:0] prdata_ff;
    logic ackValid_ff;
    logic ackExternal_ff;
    logic [7:0] ackVector_ff;
    logic strap1_ff;
    logic strap2_ff;
    logic strap3_ff;
    logic strapStable_ff;
    logic sourceSynth_ff;
    logic wrEn;
    logic rdSetup;
    logic mapped;
    logic expire;
    logic timerClaims;
    logic timerAck;
    ptmr_level_t level;
    ptmr_level_t timerLevel;
    logic [31:0] rdValue;

    ////////////////////////////////////////////////////////////////
    // bus decode
    assign wrEn = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign mapped = (paddr == CTRL_OFFSET) || (paddr == MODULUS_OFFSET)
                    || (paddr == STATUS_OFFSET) || (paddr == MASK_OFFSET)
                    || (paddr == SOURCE_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;
    assign level = ctrl_ff[LEVEL_MSB:LEVEL_LSB];

    ////////////////////////////////////////////////////////////////
    // strap synchroniser: change accepted when second and third agree
    always_ff @(posedge clock) begin
        strap1_ff <= clockSourceStrap;
        strap2_ff <= strap1_ff;
        strap3_ff <= strap2_ff;
    end

    // filtered strap level
    always_ff @(posedge clock) begin
        if (strap2_ff == strap3_ff) begin
            strapStable_ff <= strap3_ff;
        end
    end

    // clock source latched while reset is held
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sourceSynth_ff <= strapStable_ff; // RULE11
        end
    end

    assign clockSourceSynth = sourceSynth_ff;

    ////////////////////////////////////////////////////////////////
    // control register: level and vector
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RESET[10:0];
        end else if (wrEn && paddr == CTRL_OFFSET) begin
            ctrl_ff <= pwdata[10:0]; // RULE10
        end
    end

    // modulus register, writable at any time
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            modulus_ff <= MODULUS_RESET;
        end else if (wrEn && paddr == MODULUS_OFFSET) begin
            modulus_ff <= pwdata[MODULUS_MSB:MODULUS_LSB]; // RULE6
        end
    end

    // prescale select, reset from the inverted strap
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prescale_ff <= !strapStable_ff; // RULE8
        end else if (wrEn && paddr == MODULUS_OFFSET) begin
            prescale_ff <= pwdata[PRESCALE_BIT]; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////
    // prescaler
    assign tickLink.prescaleSel = prescale_ff;
    assign tickLink.running = (modulus_ff != 8'h00); // RULE5

    ptmr_prescaler u_prescaler (
        .clock(clock),
        .rst_b(rst_b),
        .link(tickLink.gen)
    );

    ////////////////////////////////////////////////////////////////
    // modulus down counter
    assign expire = tickLink.tick && (count_ff == 8'h01) && (modulus_ff != 8'h00); // RULE5

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count_ff <= MODULUS_RESET;
        end else if (modulus_ff == 8'h00) begin
            count_ff <= 8'h00; // RULE5
        end else if (wrEn && paddr == MODULUS_OFFSET) begin
            count_ff <= pwdata[MODULUS_MSB:MODULUS_LSB];
        end else if (count_ff == 8'h00 || expire) begin
            count_ff <= modulus_ff; // RULE12
        end else if (tickLink.tick) begin
            count_ff <= count_ff - 8'h01; // RULE9 RULE3
        end
    end

    ////////////////////////////////////////////////////////////////
    // request and acknowledge arbitration
    assign timerLevel = pending_ff ? level : LEVEL_OFF; // RULE1
    assign irqLevelOut = (timerLevel >= extIrqLevel) ? timerLevel : extIrqLevel;
    assign timerClaims = pending_ff && (level != LEVEL_OFF) && (iackLevel == level); // RULE2
    assign timerAck = iackReq && timerClaims;

    // pending request, set wins over acknowledge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pending_ff <= 1'b0;
        end else if (expire) begin
            pending_ff <= 1'b1; // RULE12 RULE3
        end else if (timerAck) begin
            pending_ff <= 1'b0; // RULE12
        end
    end

    // acknowledge answer one cycle after the request
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ackValid_ff <= 1'b0;
            ackExternal_ff <= 1'b0;
            ackVector_ff <= 8'h00;
        end else begin
            ackValid_ff <= timerAck;
            ackExternal_ff <= iackReq && !timerClaims; // RULE2
            if (timerAck) begin
                ackVector_ff <= ctrl_ff[VECTOR_MSB:VECTOR_LSB]; // RULE4
            end
        end
    end

    assign ackValid = ackValid_ff;
    assign ackExternal = ackExternal_ff;
    assign ackVector = ackVector_ff;

    ////////////////////////////////////////////////////////////////
    // sticky status, write one to clear, set wins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_ff <= STATUS_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == EXPIRE_BIT && expire) || (i == REQ_ACK_BIT && timerAck)) begin
                    status_ff[i] <= 1'b1;
                end else if (wrEn && paddr == STATUS_OFFSET && pwdata[i]) begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mask_ff <= MASK_RESET;
        end else if (wrEn && paddr == MASK_OFFSET) begin
            mask_ff <= pwdata[1:0];
        end
    end

    assign irq = |(status_ff & mask_ff);

    ////////////////////////////////////////////////////////////////
    // read mux, captured in the setup cycle
    always_comb begin
        rdValue = 32'h0000_0000;
        case (paddr)
            CTRL_OFFSET: rdValue = {21'h000000, ctrl_ff}; // RULE10
            MODULUS_OFFSET: rdValue = {23'h000000, prescale_ff, modulus_ff}; // RULE6
            STATUS_OFFSET: rdValue = {30'h00000000, status_ff};
            MASK_OFFSET: rdValue = {30'h00000000, mask_ff};
            SOURCE_OFFSET: rdValue = {30'h00000000, pending_ff, sourceSynth_ff};
            default: rdValue = 32'h0000_0000;
        endcase
    end

    // read data register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata_ff <= rdValue;
        end
    end
endmodule

/* File: testbench/ptmr_sva.sv */
// port checker for the periodic tick unit, bound to its top module
`timescale 1ns/1ps
module ptmr_sva
    import ptmr_pkg::*;
(
    // clock, reset and apb
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // arbitration and acknowledge
    input wire ptmr_pkg::ptmr_level_t extIrqLevel,
    input wire ptmr_pkg::ptmr_level_t iackLevel,
    input wire ptmr_pkg::ptmr_level_t irqLevelOut,
    input wire logic iackReq,
    input wire logic ackValid,
    input wire logic ackExternal,
    input wire ptmr_pkg::ptmr_vector_t ackVector
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    // an apb access phase, and an acknowledge with the cycle after it
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_iack;
        iackReq ##1 1'b1;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (s_access ##0 (paddr > SOURCE_OFFSET) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_access ##0 (paddr <= SOURCE_OFFSET) ##0
        (paddr[1:0] == 2'h0) |-> !pslverr) else $error("mapped access refused");
    a_rdata_top_zero: assert property (prdata[31:11] == 21'h0)
        else $error("unimplemented read bits not zero");
    a_ack_onehot: assert property (s_iack |-> $onehot({ackValid, ackExternal}))
        else $error("acknowledge not answered once");
    a_ack_cause: assert property (!iackReq |=> !ackValid && !ackExternal)
        else $error("acknowledge answer without request");
    a_ack_level: assert property (ackValid |-> ($past(iackLevel) != LEVEL_OFF) &&
        ($past(irqLevelOut) == $past(iackLevel))) else $error("claim at wrong level");
    a_level_floor: assert property (irqLevelOut >= extIrqLevel)
        else $error("request level below external level");
    a_vector_hold: assert property (!ackValid |-> $stable(ackVector))
        else $error("vector changed without acknowledge");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ptmr_periodic_timer ptmr_sva u_sva (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .prdata(prdata), .extIrqLevel(extIrqLevel), .iackLevel(iackLevel),
    .irqLevelOut(irqLevelOut), .iackReq(iackReq), .ackValid(ackValid),
    .ackExternal(ackExternal), .ackVector(ackVector));

/* File: testbench/ptmr_irq_host.sv */
// model of the processor interrupt arbitration and acknowledge side
`timescale 1ns/1ps
module ptmr_irq_host
    import ptmr_pkg::*;
(
    // clock
    input wire logic clock,
    // arbitration and acknowledge
    input wire ptmr_pkg::ptmr_level_t irqLevelOut,
    input wire logic ackValid,
    input wire logic ackExternal,
    output ptmr_pkg::ptmr_level_t extIrqLevel,
    output ptmr_pkg::ptmr_level_t iackLevel,
    output logic iackReq
);
    // idle: no external request, no acknowledge
    initial begin
        extIrqLevel = LEVEL_OFF;
        iackLevel = LEVEL_OFF;
        iackReq = 1'b0;
    end
    // external source asks at a level
    task set_ext(input ptmr_level_t l);
        extIrqLevel <= l;
    endtask
    // acknowledge the level shown, one-cycle pulse, report who claimed it
    task ack(output logic v, output logic e);
        iackLevel <= irqLevelOut;
        iackReq <= 1'b1;
        @(posedge clock);
        iackReq <= 1'b0;
        iackLevel <= ~irqLevelOut; // released level does not hold
        @(posedge clock);
        v = ackValid;
        e = ackExternal;
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the periodic tick unit
`timescale 1ns/1ps
module tb_top;
    import ptmr_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic strap = 1'b1, pready, pslverr, ackValid, ackExternal, irq, synth, v, e, iackReq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    ptmr_level_t extIrqLevel, iackLevel, irqLevelOut;
    ptmr_vector_t ackVector;
    int nErrors = 0, compares = 0;
    // 25 MHz clock
    always #20 clock = ~clock;
    ptmr_periodic_timer DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clockSourceStrap(strap), .clockSourceSynth(synth),
        .extIrqLevel(extIrqLevel), .iackReq(iackReq), .iackLevel(iackLevel),
        .irqLevelOut(irqLevelOut), .ackValid(ackValid), .ackExternal(ackExternal),
        .ackVector(ackVector), .irq(irq));
    ptmr_irq_host P (.clock(clock), .irqLevelOut(irqLevelOut), .ackValid(ackValid),
        .ackExternal(ackExternal), .extIrqLevel(extIrqLevel), .iackLevel(iackLevel),
        .iackReq(iackReq));
    ////////////////////////////////////////////////////////////////////////////////
    task closeOut();
        $display("compares %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // one apb transfer, held until pready, then one idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            nErrors++;
            closeOut();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data does not hold
        @(posedge clock);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", 32'h0, {31'h0, e});
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask
    // bounded wait for the interrupt line
    task wirq();
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clock);
            n++;
            if (n > 5000) begin
                nErrors++;
                closeOut();
            end
        end
    endtask
    // restart the count, then time one full expiry to expiry interval
    task period(input logic [31:0] m, input int ex);
        time t0;
        wr(MODULUS_OFFSET, m);
        wr(STATUS_OFFSET, 32'h3);
        wirq();
        t0 = $time;
        wr(STATUS_OFFSET, 32'h3);
        wirq();
        chk("period", ex, 32'(($time - t0) / CLOCK_PERIOD_NS));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs();
        rdc("control reset", CTRL_OFFSET, 32'h00F);
        rdc("modulus reset", MODULUS_OFFSET, 32'h0);
        rdc("clock source", SOURCE_OFFSET, 32'h1);
        chk("synth pin", 32'h1, {31'h0, synth});
        wr(CTRL_OFFSET, 32'hFFFFFFFF);
        rdc("control bits", CTRL_OFFSET, 32'h7FF);
        wr(MODULUS_OFFSET, 32'h1FF);
        rdc("modulus bits", MODULUS_OFFSET, 32'h1FF);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask
    task t_tick();
        wr(MASK_OFFSET, 32'h1);
        wr(CTRL_OFFSET, 32'h3A5);
        P.set_ext(3'h3);
        period(32'h002, 8);
        P.ack(v, e);
        chk("timer claim", 32'h1, {31'h0, v});
        chk("external claim", 32'h0, {31'h0, e});
        chk("vector", 32'hA5, {24'h0, ackVector});
        P.set_ext(3'h0);
        for (int l = 1; l < 8; l++) begin
            wr(CTRL_OFFSET, 32'(l * 256 + 165));
            repeat (10) @(posedge clock);
            chk("request level", 32'(l), {29'h0, irqLevelOut});
        end
    endtask
    task t_off();
        wr(CTRL_OFFSET, 32'h0A5);
        wr(MASK_OFFSET, 32'h0);
        wr(STATUS_OFFSET, 32'h3);
        repeat (20) @(posedge clock);
        chk("disabled level", 32'h0, {29'h0, irqLevelOut});
        chk("masked irq", 32'h0, {31'h0, irq});
        rdc("status running", STATUS_OFFSET, 32'h1);
        rdc("pending held", SOURCE_OFFSET, 32'h3);
        // external source asks while the timer level is off: it takes the acknowledge
        P.set_ext(3'h5);
        @(posedge clock);
        P.ack(v, e);
        chk("disabled claim", 32'h0, {31'h0, v});
        chk("external takes ack", 32'h1, {31'h0, e});
        chk("vector kept", 32'hA5, {24'h0, ackVector});
        P.set_ext(3'h0);
        wr(MODULUS_OFFSET, 32'h0);
        repeat (4) @(posedge clock);
        wr(STATUS_OFFSET, 32'h3);
        repeat (40) @(posedge clock);
        rdc("stopped status", STATUS_OFFSET, 32'h0);
        wr(MASK_OFFSET, 32'h1);
        period(32'h101, 2048);
    endtask
    // second reset with the strap low: synthesizer off, prescale on
    task t_strap();
        strap <= 1'b0;
        rst_b <= 1'b0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rdc("modulus strap low", MODULUS_OFFSET, 32'h100);
        rdc("source strap low", SOURCE_OFFSET, 32'h0);
        chk("synth pin low", 32'h0, {31'h0, synth});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_regs();
        t_tick();
        t_off();
        t_strap();
        closeOut();
    end
endmodule
